// ### rtl/addr_bus_if.sv
// Interface joining the bus master end and the arbiter/system end
`timescale 1ns/1ps
interface addr_bus_if;
  import addr_tenure_pkg::*;
  logic bus_req_n;
  logic addr_grant_n;
  logic addr_ack_n;
  logic addr_retry_n;
  logic busy_o;
  logic busy_oe;
  logic busy_sys_o;
  logic busy_sys_oe;
  logic addr_busy_n;
  logic start_o;
  logic start_oe;
  logic start_sys_o;
  logic start_sys_oe;
  logic xfer_start_n;
  logic ext_xfer_start_n;
  addr_attr_t attr_o;
  logic attr_oe;
  addr_attr_t attr_sys_o;
  logic attr_sys_oe;
  addr_attr_t attr;
  logic [PAR_W-1:0] par_o;
  logic [PAR_W-1:0] par_sys_o;
  logic [PAR_W-1:0] addr_par;
  logic addr_par_err_n;

  // Resolve shared wires from enables; pull-up when nobody drives
  assign addr_busy_n = busy_oe ? busy_o : (busy_sys_oe ? busy_sys_o : 1'b1);
  assign xfer_start_n = start_oe ? start_o : (start_sys_oe ? start_sys_o : 1'b1);
  assign attr = attr_oe ? attr_o : (attr_sys_oe ? attr_sys_o : '1);
  assign addr_par = attr_oe ? par_o : (attr_sys_oe ? par_sys_o : '1);

  modport master (
    output bus_req_n, busy_o, busy_oe, start_o, start_oe, ext_xfer_start_n,
    output attr_o, attr_oe, par_o, addr_par_err_n,
    input addr_grant_n, addr_ack_n, addr_retry_n, addr_busy_n, xfer_start_n,
    input attr, addr_par
  );
  modport system (
    input bus_req_n, addr_busy_n, xfer_start_n, ext_xfer_start_n, attr, addr_par,
    input addr_par_err_n,
    output addr_grant_n, addr_ack_n, addr_retry_n, busy_sys_o, busy_sys_oe,
    output start_sys_o, start_sys_oe, attr_sys_o, attr_sys_oe, par_sys_o
  );
endinterface

// ### rtl/addr_tenure_master.sv
// Address tenure master: request, qualified grant, transfer start, parity
//
// Function
// - Hold bus request until granted and bus free
// - Qualified grant: grant, not busy, no retry twice
// - On grant: busy, drop request, drive, start
// - Arbiter allows only one address master
// - Grant may be tied on in single-master systems
// - Parked: grant taken edge after need arises
// - Busy negated one clock after acknowledge
// - Cancelled request may leave grant unused
// - Start only with valid address and attributes
// - Track foreign start with or after busy
// - Acknowledge no earlier than clock after start
// - Drive odd parity per address byte
// - Check snooped parity, flag error on mismatch
// - Parity error: machine check or checkstop
// - At most two own transactions pipelined
// - Data tenures complete in address order
// - Arbiter sets pipeline depth by grant timing
// - Address and attribute field widths
// - Extended start unused for memory accesses
// - Parked grant needs no bus request
`timescale 1ns/1ps
module addr_tenure_master
  import addr_tenure_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Bus side
  addr_bus_if.master bus,
  // Access request from the core
  input wire logic req_valid,
  input addr_attr_t req_attr,
  input wire logic req_cancel,
  output logic req_taken,
  // Data tenure completion, one pulse per finished data tenure in order
  input wire logic data_done,
  // Parity checking controls and outcome
  input wire logic addr_par_check_en,
  input wire logic machine_check_en,
  input wire logic [TYPE_W-1:0] snoop_type_mask_sel,
  input wire logic snoop_type_hit,
  output logic machine_check,
  output logic checkstop,
  // Status
  output logic [1:0] own_pending
);
  master_state_t state;
  logic retry_prev;
  logic qual_grant;
  logic need_bus;
  logic pipe_full;
  logic take;
  logic par_err;
  addr_attr_t drive_attr;

  // ------------------------------------------------------------
  // Arbitration
  // ------------------------------------------------------------
  // Retry history: a grant qualifies only after two retry-free cycles
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      retry_prev <= 1'b1;
    end else begin
      retry_prev <= bus.addr_retry_n;
    end
  end

  assign qual_grant = !bus.addr_grant_n && bus.addr_busy_n &&
                      bus.addr_retry_n && retry_prev;
  assign pipe_full = (own_pending >= 2'(MAX_OWN_PIPE));
  assign need_bus = req_valid && !req_cancel && !pipe_full;
  // Parked or requested: grant taken whenever qualified, no request needed
  assign take = need_bus && qual_grant &&
                (state == M_IDLE || state == M_REQ);
  assign req_taken = take;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state <= M_IDLE;
    end else begin
      case (state)
        M_IDLE: begin
          if (take) begin
            state <= M_TENURE;
          end else if (need_bus) begin
            state <= M_REQ;
          end
        end
        M_REQ: begin
          if (take) begin
            state <= M_TENURE;
          end else if (!need_bus) begin
            state <= M_IDLE;
          end
        end
        M_TENURE: begin
          if (!bus.addr_ack_n) begin
            state <= M_GAP;
          end
        end
        M_GAP: begin
          state <= M_IDLE;
        end
        default: begin
          state <= M_IDLE;
        end
      endcase
    end
  end

  // Request held while waiting; dropped in the cycle after the grant cycle, together with busy
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      bus.bus_req_n <= 1'b1;
    end else begin
      bus.bus_req_n <= !(need_bus && !take &&
                         (state == M_IDLE || state == M_REQ));
    end
  end

  // ------------------------------------------------------------
  // Address transfer
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      drive_attr <= '0;
    end else if (take) begin
      drive_attr <= req_attr;
    end
  end

  // Start pulses in the first tenure cycle only, together with busy
  logic start_pend;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      start_pend <= 1'b0;
    end else begin
      start_pend <= take;
    end
  end

  always_comb begin
    bus.busy_oe = (state == M_TENURE);
    bus.busy_o = 1'b0;
    bus.start_oe = (state == M_TENURE);
    bus.start_o = !start_pend;
    bus.attr_oe = (state == M_TENURE);
    bus.attr_o = drive_attr;
    bus.par_o = odd_par(drive_attr.addr);
    bus.ext_xfer_start_n = 1'b1;
  end

  // ------------------------------------------------------------
  // Own pipeline depth, data in address order
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      own_pending <= PIPE_CNT_RST;
    end else begin
      case ({take, data_done && own_pending != 2'h0})
        2'b10: own_pending <= own_pending + 2'h1;
        2'b01: own_pending <= own_pending - 2'h1;
        default: own_pending <= own_pending;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Snoop tracking and parity check
  // ------------------------------------------------------------
  // Another master owns the bus from its busy until busy drops again
  logic foreign_tenure;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      foreign_tenure <= 1'b0;
    end else if (state != M_TENURE && !bus.addr_busy_n) begin
      foreign_tenure <= 1'b1;
    end else if (bus.addr_busy_n) begin
      foreign_tenure <= 1'b0;
    end
  end

  // A foreign start counts together with busy or in any later busy cycle
  logic snoop_window;
  logic snoop_start;
  logic [PAR_W-1:0] snoop_par;
  assign snoop_window = (state != M_TENURE) && (foreign_tenure || !bus.addr_busy_n);
  assign snoop_start = snoop_window && !bus.xfer_start_n && !bus.attr.global &&
                       snoop_type_hit;
  assign snoop_par = odd_par(bus.attr.addr);
  assign par_err = snoop_start && (bus.addr_par != snoop_par);

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      bus.addr_par_err_n <= 1'b1;
      machine_check <= 1'b0;
      checkstop <= 1'b0;
    end else begin
      bus.addr_par_err_n <= !par_err;
      machine_check <= par_err && addr_par_check_en && machine_check_en;
      checkstop <= checkstop || (par_err && addr_par_check_en && !machine_check_en);
    end
  end
endmodule

// ### rtl/addr_tenure_pkg.sv
// Shared constants and types for the address tenure link
package addr_tenure_pkg;
  localparam int ADDR_W = 32;
  localparam int PAR_W = 4;
  localparam int TYPE_W = 5;
  localparam int CODE_W = 3;
  localparam int SIZE_W = 3;
  localparam int CSE_W = 2;
  localparam int MAX_OWN_PIPE = 2;
  localparam logic [1:0] PIPE_CNT_RST = 2'h0;
  localparam int ACK_MIN_CYCLES = 1;
  localparam int IDLE_AFTER_ACK = 1;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [TYPE_W-1:0] xfer_type;
    logic [CODE_W-1:0] xfer_code;
    logic [SIZE_W-1:0] xfer_size;
    logic burst;
    logic inhibit;
    logic write_thru;
    logic global;
    logic [CSE_W-1:0] set_element;
  } addr_attr_t;

  typedef enum logic [2:0] {
    M_IDLE,
    M_REQ,
    M_TENURE,
    M_GAP
  } master_state_t;

  // Odd parity over one byte: bit is set when byte holds an even count of ones
  function automatic logic [PAR_W-1:0] odd_par(input logic [ADDR_W-1:0] a);
    logic [PAR_W-1:0] p;
    p = '0;
    for (int i = 0; i < PAR_W; i++) begin
      p[i] = ~(^a[i*8 +: 8]);
    end
    return p;
  endfunction
endpackage

// ### rtl/addr_tenure_system.sv
// System end: central arbiter with parking and address acknowledge
`timescale 1ns/1ps
module addr_tenure_system
  import addr_tenure_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Bus side
  addr_bus_if.system bus,
  // Arbitration policy
  input wire logic park_grant,
  input wire logic [3:0] ack_delay,
  input wire logic retry_req,
  // Observed transfer
  output logic start_seen,
  output addr_attr_t seen_attr
);
  logic ack_wait;
  logic [3:0] ack_cnt;

  // ------------------------------------------------------------
  // Grant, withheld while a tenure runs so only one master exists
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      bus.addr_grant_n <= 1'b1;
    end else begin
      bus.addr_grant_n <= !((park_grant || !bus.bus_req_n) &&
                            bus.addr_busy_n && !ack_wait);
    end
  end

  // ------------------------------------------------------------
  // Acknowledge at least one clock after start
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ack_wait <= 1'b0;
      ack_cnt <= 4'h0;
      bus.addr_ack_n <= 1'b1;
      bus.addr_retry_n <= 1'b1;
      start_seen <= 1'b0;
      seen_attr <= '0;
    end else begin
      start_seen <= !bus.xfer_start_n;
      bus.addr_ack_n <= 1'b1;
      bus.addr_retry_n <= 1'b1;
      if (!bus.xfer_start_n && !ack_wait) begin
        ack_wait <= 1'b1;
        ack_cnt <= ack_delay;
        seen_attr <= bus.attr;
        if (ack_delay == 4'h0) begin
          bus.addr_ack_n <= 1'b0;
          bus.addr_retry_n <= !retry_req;
          ack_wait <= 1'b0;
        end
      end else if (ack_wait) begin
        if (ack_cnt <= 4'h1) begin
          bus.addr_ack_n <= 1'b0;
          bus.addr_retry_n <= !retry_req;
          ack_wait <= 1'b0;
        end else begin
          ack_cnt <= ack_cnt - 4'h1;
        end
      end
    end
  end

  always_comb begin
    bus.busy_sys_o = 1'b1;
    bus.busy_sys_oe = 1'b0;
    bus.start_sys_o = 1'b1;
    bus.start_sys_oe = 1'b0;
    bus.attr_sys_o = '1;
    bus.attr_sys_oe = 1'b0;
    bus.par_sys_o = '1;
  end
endmodule

// ### tb/addr_tenure_assertions.sv
// Checker for the address tenure link between the master and system ends
`timescale 1ns/1ps
module addr_tenure_assertions
  import addr_tenure_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Shared bus wires and master enables
  input wire logic bus_req_n,
  input wire logic addr_grant_n,
  input wire logic addr_ack_n,
  input wire logic addr_retry_n,
  input wire logic addr_busy_n,
  input wire logic xfer_start_n,
  input wire logic busy_oe,
  input wire logic start_oe,
  input wire logic attr_oe,
  input addr_attr_t attr,
  input wire logic [PAR_W-1:0] addr_par
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence take_s;
    $rose(busy_oe) && !xfer_start_n;
  endsequence
  sequence own_ack_s;
    busy_oe && !addr_ack_n;
  endsequence
  qual_grant_a: assert property ($rose(busy_oe) |-> !$past(addr_grant_n)
    && $past(addr_busy_n) && $past(addr_retry_n) && $past(addr_retry_n, 2))
    else $error("take without qualified grant");
  start_busy_a: assert property (start_oe && !xfer_start_n |->
    busy_oe && !addr_busy_n && attr_oe) else $error("start without busy");
  req_drop_a: assert property (take_s |-> bus_req_n) else $error("request kept");
  start_once_a: assert property (take_s |=> xfer_start_n) else $error("long start");
  ack_min_a: assert property ($fell(xfer_start_n) |-> addr_ack_n)
    else $error("ack with start");
  ack_max_a: assert property ($fell(xfer_start_n) |-> ##[1:16] !addr_ack_n)
    else $error("ack missing");
  gap_a: assert property (own_ack_s |=> !busy_oe) else $error("no idle gap");
  release_a: assert property (!busy_oe |-> !start_oe && !attr_oe)
    else $error("driving while idle");
  odd_par_a: assert property (attr_oe |-> addr_par == {~^attr.addr[31:24],
    ~^attr.addr[23:16], ~^attr.addr[15:8], ~^attr.addr[7:0]}) else $error("bad parity");
endmodule

// ### tb/address_bus_tenure_master_bench.sv
// Self-checking bench for the master and system ends of the address tenure link
`timescale 1ns/1ps
module address_bus_tenure_master_bench;
  import addr_tenure_pkg::*;
  logic clk, reset_n, req_valid, req_cancel, req_taken, data_done, check_en, mc_en;
  logic machine_check, checkstop, park_grant, start_seen, snoop_hit;
  logic [TYPE_W-1:0] mask_sel;
  logic [1:0] own_pending;
  logic [3:0] ack_delay;
  addr_attr_t req_attr, seen_attr;
  int bad_count, checks_done;
  addr_bus_if bus ();
  addr_bus_if bus2 ();
  addr_tenure_master addr_tenure_master_i (.clk(clk), .reset_n(reset_n), .bus(bus),
    .req_valid(req_valid), .req_attr(req_attr), .req_cancel(req_cancel),
    .req_taken(req_taken), .data_done(data_done), .addr_par_check_en(check_en),
    .machine_check_en(mc_en), .snoop_type_mask_sel(mask_sel), .snoop_type_hit(1'b1),
    .machine_check(), .checkstop(), .own_pending(own_pending));
  // Snooping end, faced by the bench acting as a foreign master
  addr_tenure_master addr_tenure_master_i2 (.clk(clk), .reset_n(reset_n), .bus(bus2),
    .req_valid(1'b0), .req_attr('0), .req_cancel(req_cancel), .req_taken(),
    .data_done(1'b0), .addr_par_check_en(check_en), .machine_check_en(mc_en),
    .snoop_type_mask_sel(mask_sel), .snoop_type_hit(snoop_hit),
    .machine_check(machine_check), .checkstop(checkstop), .own_pending());
  addr_tenure_system addr_tenure_system_i (.clk(clk), .reset_n(reset_n), .bus(bus),
    .park_grant(park_grant), .ack_delay(ack_delay), .retry_req(1'b0),
    .start_seen(start_seen), .seen_attr(seen_attr));
  addr_tenure_assertions addr_tenure_assertions_i (.clk(clk), .reset_n(reset_n),
    .bus_req_n(bus.bus_req_n), .addr_grant_n(bus.addr_grant_n),
    .addr_ack_n(bus.addr_ack_n), .addr_retry_n(bus.addr_retry_n),
    .addr_busy_n(bus.addr_busy_n), .xfer_start_n(bus.xfer_start_n),
    .busy_oe(bus.busy_oe), .start_oe(bus.start_oe), .attr_oe(bus.attr_oe),
    .attr(bus.attr), .addr_par(bus.addr_par));

  task automatic check(input logic ok, input string msg);
    checks_done++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic xfer(input addr_attr_t a, input logic [3:0] d, input logic parked);
    int n;
    int s;
    n = 0;
    s = 0;
    ack_delay = d;
    req_attr = a;
    req_valid = 1'b1;
    #1;
    while (req_taken !== 1'b1 && n < 20) begin
      @(negedge clk);
      #1;
      n++;
    end
    check(parked ? (n == 0 && bus.bus_req_n === 1'b1) : n > 0, "grant wait");
    @(negedge clk);
    req_valid = 1'b0;
    check(bus.xfer_start_n === 1'b0 && bus.attr === a &&
          bus.ext_xfer_start_n === 1'b1, "start");
    n = 1;
    while (bus.addr_ack_n !== 1'b0 && n < 20) begin
      @(negedge clk);
      s += (start_seen === 1'b1);
      n++;
    end
    check(n == d + 2 && seen_attr === a && s == 1, "ack");
    @(negedge clk);
    check(bus.addr_busy_n === 1'b1, "gap");
    @(negedge clk);
    $display("xfer test done");
  endtask

  task automatic done_pulse(input logic [1:0] left);
    data_done = 1'b1;
    @(negedge clk);
    data_done = 1'b0;
    check(own_pending === left, "pending");
    @(negedge clk);
  endtask

  task automatic pipe_test();
    int n;
    n = 0;
    xfer(49'h1_2345_6789_abcd, 4'h0, 1'b0);
    xfer(49'h0_fedc_ba98_7654, 4'h3, 1'b0);
    check(own_pending === 2'h2, "two pending");
    req_valid = 1'b1;
    repeat (6) begin
      @(negedge clk);
      #1;
      n += (req_taken === 1'b1);
    end
    req_valid = 1'b0;
    check(n == 0, "third taken");
    park_grant = 1'b1;
    done_pulse(2'h1);
    @(negedge clk);
    xfer(49'h1_ffff_ffff_fffc, 4'hf, 1'b1);
    done_pulse(2'h1);
    done_pulse(2'h0);
    park_grant = 1'b0;
    @(negedge clk);
    $display("pipe test done");
  endtask

  task automatic cancel_test();
    int n;
    n = 0;
    req_valid = 1'b1;
    @(negedge clk);
    @(negedge clk);
    check(bus.bus_req_n === 1'b0, "no request");
    req_cancel = 1'b1;
    req_valid = 1'b0;
    repeat (6) begin
      @(negedge clk);
      n += (req_taken === 1'b1 || bus.busy_oe === 1'b1);
    end
    req_cancel = 1'b0;
    check(n == 0 && bus.bus_req_n === 1'b1, "cancel");
    $display("cancel test done");
  endtask

  task automatic snoop(input logic bad, en, me, mc, cs, hit);
    int errs, mcs;
    logic [31:0] a;
    errs = 0;
    mcs = 0;
    a = bus2.attr_sys_o.addr;
    check_en = en;
    mc_en = me;
    snoop_hit = hit;
    bus2.busy_sys_oe = 1'b1;
    @(negedge clk);
    bus2.start_sys_oe = 1'b1;
    bus2.par_sys_o = {~^a[31:24], ~^a[23:16], ~^a[15:8], ~^a[7:0] ^ bad};
    repeat (3) begin
      @(negedge clk);
      bus2.start_sys_oe = 1'b0;
      errs += (bus2.addr_par_err_n === 1'b0);
      mcs += (machine_check === 1'b1);
    end
    bus2.busy_sys_oe = 1'b0;
    check(errs == (bad && hit) && mcs == mc && checkstop === cs, "parity");
    @(negedge clk);
    $display("snoop test done");
  endtask

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Whole run needs some 90 cycles; allow far more
  initial begin
    #200000;
    bad_count++;
    report_and_stop();
  end

  initial begin
    {reset_n, req_valid, req_cancel, data_done, check_en, mc_en, park_grant, snoop_hit} = '0;
    {mask_sel, ack_delay, req_attr, bad_count, checks_done} = '0;
    {bus2.addr_grant_n, bus2.addr_ack_n, bus2.addr_retry_n, bus2.attr_sys_oe} = 4'hf;
    {bus2.busy_sys_o, bus2.busy_sys_oe, bus2.start_sys_o, bus2.start_sys_oe} = 4'h0;
    bus2.par_sys_o = 4'h0;
    bus2.attr_sys_o = '1;
    bus2.attr_sys_o.addr = 32'h5a3c_0f81;
    bus2.attr_sys_o.global = 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    reset_n = 1'b1;
    pipe_test();
    cancel_test();
    snoop(1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1);
    snoop(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
    snoop(1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1);
    snoop(1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
    snoop(1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
    report_and_stop();
  end
endmodule
